//--- design/sfpt_pkg.sv
// package for the flash parameter table rom: offsets, byte values, request/answer carriers
`default_nettype none
package sfpt_pkg;
   localparam int unsigned OFF_W = 8;                // byte offset width
   // parameter-table offsets
   localparam logic [7:0] OFF_DENSITY  = 8'h07;      // density msb
   localparam logic [7:0] OFF_Q144_CYC = 8'h08;      // 1-4-4 mode/dummy
   localparam logic [7:0] OFF_Q144_OP  = 8'h09;      // 1-4-4 opcode
   localparam logic [7:0] OFF_Q114_CYC = 8'h0a;      // 1-1-4 mode/dummy
   localparam logic [7:0] OFF_Q114_OP  = 8'h0b;      // 1-1-4 opcode
   localparam logic [7:0] OFF_D112_CYC = 8'h0c;      // 1-1-2 mode/dummy
   localparam logic [7:0] OFF_D112_OP  = 8'h0d;      // 1-1-2 opcode
   localparam logic [7:0] OFF_D122_CYC = 8'h0e;      // 1-2-2 mode/dummy
   localparam logic [7:0] OFF_D122_OP  = 8'h0f;      // 1-2-2 opcode
   localparam logic [7:0] OFF_SUPPORT  = 8'h10;      // support flags
   localparam logic [7:0] OFF_RSV_LO   = 8'h11;      // reserved run start
   localparam logic [7:0] OFF_RSV_HI   = 8'h15;      // reserved run end
   localparam logic [7:0] OFF_D222_CYC = 8'h16;      // 2-2-2 mode/dummy
   localparam logic [7:0] OFF_D222_OP  = 8'h17;      // 2-2-2 opcode
   localparam logic [7:0] OFF_RSV2_LO  = 8'h18;      // reserved pair start
   localparam logic [7:0] OFF_RSV2_HI  = 8'h19;      // reserved pair end
   localparam logic [7:0] OFF_FLCM_CYC = 8'h1a;      // four-lane mode/dummy
   localparam logic [7:0] OFF_FLCM_OP  = 8'h1b;      // four-lane opcode
   localparam logic [7:0] OFF_ERASE1_SZ = 8'h1c;     // erase type 1 size
   localparam logic [7:0] OFF_ERASE1_OP = 8'h1d;     // erase type 1 opcode
   localparam logic [7:0] ALT_SHIFT    = 8'h02;      // alternate query offset bias
   // field values
   localparam logic [2:0] MODE_Q144  = 3'h2;         // 010b
   localparam logic [4:0] DUMMY_DEF  = 5'h08;        // 01000b
   localparam logic [2:0] MODE_D122  = 3'h4;         // 100b
   localparam logic [2:0] MODE_NONE  = 3'h7;         // 111b
   localparam logic [4:0] DUMMY_NONE = 5'h1f;        // 11111b
   localparam logic [7:0] OP_Q144    = 8'heb;        // 1-4-4 read opcode
   localparam logic [7:0] OP_D122    = 8'hbb;        // 1-2-2 read opcode
   localparam logic [7:0] OP_NONE    = 8'hff;        // unsupported opcode
   localparam logic [7:0] BYTE_RSV   = 8'hff;        // reserved byte
   localparam logic [7:0] BYTE_SUPPORT = 8'hfe;      // flags byte
   localparam int unsigned SUP_FLCM_BIT = 4;         // four-lane mode supported
   localparam int unsigned SUP_D222_BIT = 0;         // 2-2-2 supported
   localparam logic [7:0] DENSITY_MSB = 8'h3f;       // 1 Gb zero-based msb
   localparam logic [7:0] ERASE1_SZ  = 8'h0c;        // 4 KB as power of two
   localparam logic [7:0] ERASE1_OP  = 8'h20;        // erase type 1 opcode
   localparam logic [7:0] OUT_OF_TABLE = 8'hff;      // bytes outside this slice

   // read request
   typedef struct packed {
      logic             valid;                       // request strobe
      logic             alt;                         // alternate query space
      logic [OFF_W-1:0] offset;                      // byte offset
   } sfpt_req_t;

   // read answer
   typedef struct packed {
      logic       valid;                             // answer strobe
      logic [7:0] data;                              // table byte
   } sfpt_rsp_t;
endpackage
`default_nettype wire

//--- design/sfpt_rom.sv
// parameter table rom answering byte reads in one clock
// What this block does
// - offset 08h returns 48h, 1-4-4 cycles
// - offset 09h returns EBh, 1-4-4 opcode
// - offsets 0Ah, 0Bh return FFh, no 1-1-4
// - offsets 0Ch, 0Dh return FFh, no 1-1-2
// - offset 0Eh returns 88h, 1-2-2 cycles
// - offset 0Fh returns BBh, 1-2-2 opcode
// - offset 10h returns FEh support flags
// - reserved 11h-15h, 18h-19h read FFh
// - offsets 16h, 17h return FFh, no 2-2-2
// - offset 1Ah returns 48h, four-lane cycles
// - offset 1Bh returns EBh, four-lane opcode
// - offsets 1Ch, 1Dh return 0Ch and 20h
`timescale 1ns/1ps
`default_nettype none
module sfpt_rom
   import sfpt_pkg::*;
(
   input  wire logic      i_clk,          // serial-side clock, 50 MHz
   input  wire logic      i_nrst,         // async reset, active low
   input  wire sfpt_req_t i_req,          // read request, same clock domain
   output var sfpt_rsp_t  o_rsp           // registered answer
);

   // table lookup by parameter-table offset
   // anything outside 07h-1dh reads ones, the way an erased byte would, so a host
   // that strays past this slice sees a harmless value rather than a stale one
   function automatic logic [7:0] table_byte(input logic [7:0] off);
      logic [7:0] b;
      b = OUT_OF_TABLE;                                       // outside slice reads ones
      if (off == OFF_DENSITY) begin
         b = DENSITY_MSB;
      end else if (off == OFF_Q144_CYC) begin
         b = {MODE_Q144, DUMMY_DEF};
      end else if (off == OFF_Q144_OP) begin
         b = OP_Q144;
      end else if (off == OFF_Q114_CYC || off == OFF_D112_CYC || off == OFF_D222_CYC) begin
         b = {MODE_NONE, DUMMY_NONE};
      end else if (off == OFF_Q114_OP || off == OFF_D112_OP || off == OFF_D222_OP) begin
         b = OP_NONE;
      end else if (off == OFF_D122_CYC) begin
         b = {MODE_D122, DUMMY_DEF};
      end else if (off == OFF_D122_OP) begin
         b = OP_D122;
      end else if (off == OFF_SUPPORT) begin
         b = BYTE_SUPPORT;
      end else if ((off >= OFF_RSV_LO && off <= OFF_RSV_HI) ||
                   (off >= OFF_RSV2_LO && off <= OFF_RSV2_HI)) begin
         b = BYTE_RSV;
      end else if (off == OFF_FLCM_CYC) begin
         b = {MODE_Q144, DUMMY_DEF};
      end else if (off == OFF_FLCM_OP) begin
         b = OP_Q144;
      end else if (off == OFF_ERASE1_SZ) begin
         b = ERASE1_SZ;
      end else if (off == OFF_ERASE1_OP) begin
         b = ERASE1_OP;
      end
      return b;
   endfunction

   logic       rst_s1_q;      // reset sync stage 1
   logic       rst_s2_q;      // reset sync stage 2, design reset
   logic [7:0] poff;          // offset mapped to parameter space
   logic       alt_low;       // alternate offset below bias
   sfpt_rsp_t  rsp_q;         // answer flops behind o_rsp

   // reset release through two flops
   // entry is immediate; release waits two edges so no flop leaves reset on a ragged edge
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   // alternate space sits two bytes higher; below the bias maps nowhere
   // the wrap below the bias is caught by alt_low rather than trusted to the subtraction
   assign alt_low = i_req.alt && (i_req.offset < ALT_SHIFT);
   assign poff    = i_req.alt ? (i_req.offset - ALT_SHIFT) : i_req.offset;

   // answer register: one cycle after request; data is left alone on idle cycles so
   // a slow host may sample it late, the strobe alone marks a fresh byte
   always_ff @(posedge i_clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         rsp_q <= '0;                                         // quiet until released
      end else begin
         rsp_q.valid <= i_req.valid;                          // one-cycle answer strobe
         if (i_req.valid) begin
            rsp_q.data <= alt_low ? OUT_OF_TABLE : table_byte(poff);
         end
      end
   end

   // port comes straight off the answer flops
   assign o_rsp = rsp_q;

   // reference view of the table as the alternate space sees it; kept apart from
   // table_byte on purpose, so a slip in the lookup cannot also slip into the check
   function automatic logic [7:0] alt_ref(input logic [7:0] a);
      logic [7:0] v;
      v = 8'hff;                                              // below 09h, gaps and 20h up
      if (a == 8'h09) begin
         v = 8'h3f;                                           // density msb
      end else if (a == 8'h0a || a == 8'h1c) begin
         v = 8'h48;                                           // 1-4-4 and four-lane cycles
      end else if (a == 8'h0b || a == 8'h1d) begin
         v = 8'heb;                                           // 1-4-4 and four-lane opcode
      end else if (a == 8'h10) begin
         v = 8'h88;                                           // 1-2-2 cycles
      end else if (a == 8'h11) begin
         v = 8'hbb;                                           // 1-2-2 opcode
      end else if (a == 8'h12) begin
         v = 8'hfe;                                           // support flags
      end else if (a == 8'h1e) begin
         v = 8'h0c;                                           // erase type 1 size
      end else if (a == 8'h1f) begin
         v = 8'h20;                                           // erase type 1 opcode
      end
      return v;
   endfunction

   // checks: each parameter-space byte against the value its rule gives, written out
   a_dens_byte: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && !i_req.alt && i_req.offset == OFF_DENSITY |=> o_rsp.data == 8'h3f)
      else $error("density byte wrong");
   a_q144_cyc: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && !i_req.alt && i_req.offset == OFF_Q144_CYC |=> o_rsp.data == 8'h48)
      else $error("1-4-4 cycles wrong");
   a_q144_op: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && !i_req.alt && i_req.offset == OFF_Q144_OP |=> o_rsp.data == 8'heb)
      else $error("1-4-4 opcode wrong");

   // unsupported read types read all ones in every field
   a_q114_none: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && !i_req.alt && (i_req.offset == 8'h0a || i_req.offset == 8'h0b)
      |=> o_rsp.data == 8'hff)
      else $error("1-1-4 not ones");
   a_d112_none: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && !i_req.alt && (i_req.offset == 8'h0c || i_req.offset == 8'h0d)
      |=> o_rsp.data == 8'hff)
      else $error("1-1-2 not ones");

   // dual i/o entries
   a_d122_cyc: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && !i_req.alt && i_req.offset == OFF_D122_CYC |=> o_rsp.data == 8'h88)
      else $error("1-2-2 cycles wrong");
   a_d122_op: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && !i_req.alt && i_req.offset == OFF_D122_OP |=> o_rsp.data == 8'hbb)
      else $error("1-2-2 opcode wrong");

   // flag byte, reserved runs and the absent 2-2-2 mode
   a_support_flags: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && !i_req.alt && i_req.offset == OFF_SUPPORT
      |=> o_rsp.data == 8'hfe && o_rsp.data[SUP_FLCM_BIT] && !o_rsp.data[SUP_D222_BIT])
      else $error("support flags wrong");
   a_rsv_ones: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && !i_req.alt && ((i_req.offset >= 8'h11 && i_req.offset <= 8'h15) ||
      i_req.offset == 8'h18 || i_req.offset == 8'h19) |=> o_rsp.data == 8'hff)
      else $error("reserved byte not ones");
   a_d222_none: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && !i_req.alt && (i_req.offset == 8'h16 || i_req.offset == 8'h17)
      |=> o_rsp.data == 8'hff)
      else $error("2-2-2 not ones");

   // four-lane command mode entries
   a_flcm_cyc: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && !i_req.alt && i_req.offset == OFF_FLCM_CYC |=> o_rsp.data == 8'h48)
      else $error("four-lane cycles wrong");
   a_flcm_op: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && !i_req.alt && i_req.offset == OFF_FLCM_OP |=> o_rsp.data == 8'heb)
      else $error("four-lane opcode wrong");

   // alternate space, every offset, against the separate reference above
   // the two lowest alternate offsets have no parameter byte behind them
   a_alt_match: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && i_req.alt |=> o_rsp.data == alt_ref($past(i_req.offset)))
      else $error("alternate byte mismatch");
   a_alt_low: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && i_req.alt && i_req.offset < 8'h02 |=> o_rsp.data == 8'hff)
      else $error("alternate low byte not ones");

   // first erase type, at the end of this slice, and everything outside it
   a_erase_one: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && !i_req.alt && i_req.offset == OFF_ERASE1_SZ |=> o_rsp.data == 8'h0c)
      else $error("erase size wrong");
   a_erase_op: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && !i_req.alt && i_req.offset == OFF_ERASE1_OP |=> o_rsp.data == 8'h20)
      else $error("erase opcode wrong");
   a_plain_outside: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && !i_req.alt && (i_req.offset < 8'h07 || i_req.offset > 8'h1d) |=> o_rsp.data == 8'hff)
      else $error("byte outside table not ones");

   // answer timing: strobe one cycle late, data stands until the next read
   a_answer_once: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      o_rsp.valid == $past(i_req.valid))
      else $error("answer strobe not one cycle after request");
   a_idle_quiet: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      !i_req.valid |=> !o_rsp.valid)
      else $error("answer strobe without request");
   a_data_holds: assert property (@(posedge i_clk) disable iff (!rst_s2_q)
      !i_req.valid |=> $stable(o_rsp.data))
      else $error("answer data moved without request");
   a_reset_quiet: assert property (@(posedge i_clk)
      !rst_s2_q |-> o_rsp == '0)
      else $error("answer not quiet in reset");

   // scenarios the bench is expected to reach: plain and alternate reads,
   // reads every cycle, the low alternate corner and a byte held over idle cycles
   c_plain_read: cover property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && !i_req.alt ##1 o_rsp.valid);
   c_alt_read: cover property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && i_req.alt && i_req.offset == 8'h0a ##1 o_rsp.data == 8'h48);
   c_back_to_back: cover property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid [*3]);
   c_alt_low: cover property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid && i_req.alt && i_req.offset < 8'h02 ##1 o_rsp.data == 8'hff);
   c_idle_hold: cover property (@(posedge i_clk) disable iff (!rst_s2_q)
      i_req.valid ##1 !i_req.valid [*2]);
endmodule
`default_nettype wire

//--- testbench/sfpt_host_model.sv
// host-side model that presents table reads and keeps the last answered byte
`timescale 1ns/1ps
`default_nettype none
module sfpt_host_model
   import sfpt_pkg::*;
(
   input  wire logic       i_clk,    // table clock
   input  wire logic       i_go,     // issue a read this cycle
   input  wire logic       i_alt,    // alternate query space
   input  wire logic [7:0] i_off,    // byte offset
   input  wire sfpt_rsp_t  i_rsp,    // answer from the table
   output var sfpt_req_t   o_req,    // request to the table
   output var logic [7:0]  o_last_q  // last byte seen
);
   // idle offset is inverted so a stale value never looks like a live request
   assign o_req = '{valid: i_go, alt: i_alt, offset: (i_go ? i_off : ~i_off)};
   // capture the answered byte, as a host shift register would
   always_ff @(posedge i_clk) begin
      if (i_rsp.valid) begin
         o_last_q <= i_rsp.data;
      end
   end
endmodule
`default_nettype wire

//--- testbench/sfpt_rom_bench.sv
// self-checking bench for the parameter table rom
`timescale 1ns/1ps
`default_nettype none
module sfpt_rom_bench import sfpt_pkg::*;;
   logic       i_clk = 1'b0;    // 50 MHz clock
   logic       i_nrst = 1'b0;   // active-low reset
   logic       go = 1'b0;       // request strobe to the host model
   logic       alt = 1'b0;      // alternate space select
   logic [7:0] off = 8'h00;     // request offset
   sfpt_req_t  req;             // request into the table
   sfpt_rsp_t  rsp;             // answer from the table
   logic [7:0] last_byte;       // byte captured by the host model
   logic [8:0] prev = 9'h000;   // expected answer {valid, data}
   logic [7:0] held = 8'h00;    // data the table should still show
   int         error_cnt = 0;   // mismatches
   int         check_count = 0; // comparisons
   int         seed = 59;       // fixed seed keeps the run repeatable
   int         k;               // loop index
   int         r;               // random draw

   always #10 i_clk = ~i_clk;

   sfpt_rom u_sfpt_rom (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(req), .o_rsp(rsp));
   sfpt_host_model u_sfpt_host_model (.i_clk(i_clk), .i_go(go), .i_alt(alt), .i_off(off),
                                      .i_rsp(rsp), .o_req(req), .o_last_q(last_byte));

   // expected byte; alternate offsets below two wrap out of the table
   function automatic logic [7:0] exp_byte(input logic a, input logic [7:0] o);
      logic [7:0] p;
      p = a ? o - 8'h02 : o;
      case (p)
         8'h07: return 8'h3f;
         8'h08, 8'h1a: return 8'h48;
         8'h09, 8'h1b: return 8'heb;
         8'h0e: return 8'h88;
         8'h0f: return 8'hbb;
         8'h10: return 8'hfe;
         8'h1c: return 8'h0c;
         8'h1d: return 8'h20;
         default: return 8'hff;
      endcase
   endfunction

   // one comparison, counted
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] want);
      check_count++;
      if (seen !== want) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, want, seen);
      end
   endtask

   // drive one cycle, then judge the answer to the previous cycle's request
   task automatic step(input logic v, input logic a, input logic [7:0] o);
      @(posedge i_clk);
      go <= v;
      alt <= a;
      off <= o;
      #1;
      check("answer", rsp, prev);
      if (v) held = exp_byte(a, o);
      prev = {v, held};
   endtask

   // reset held 16 cycles; wait past the internal two-flop release
   task automatic do_reset();
      @(posedge i_clk);
      i_nrst <= 1'b0;
      go <= 1'b0;
      #1;
      check("reset answer", rsp, 9'h000);
      repeat (16) @(posedge i_clk);
      i_nrst <= 1'b1;
      repeat (4) @(posedge i_clk);
      prev = 9'h000;
      held = 8'h00;
   endtask

   // verdict and end of run
   task automatic results();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // main sequence: full sweeps back to back, random traffic, mid-run reset
   initial begin
      do_reset();
      for (k = 0; k < 512; k++) step(1'b1, k[8], k[7:0]);
      step(1'b0, 1'b0, 8'h00);
      for (k = 0; k < 300; k++) begin
         r = $random(seed);
         step(r[0], r[1], r[2] ? r[15:8] : {3'h0, r[12:8]});
      end
      do_reset();
      for (k = 0; k < 40; k++) step(1'b1, k[0], k[7:0]);
      step(1'b0, 1'b1, 8'h0a);
      step(1'b0, 1'b0, 8'h00);
      check("host byte", {1'b0, last_byte}, {1'b0, held});
      results();
   end

   // watchdog well beyond the expected run of about 900 cycles
   initial begin
      #(20 * 5000);
      error_cnt++;
      results();
   end
endmodule
`default_nettype wire
